// File: dv/dms_src_model.sv
// Sample source model: hands one complex I/Q pair to the core per call.
// Assumes callers run off the falling edge of clk.
`timescale 1ns/100ps
`default_nettype none
module dms_src_model (
  input wire logic clk,
  output logic signed [15:0] d_i,
  output logic signed [15:0] d_q,
  output logic vld
);
  // ******
  // Driver
  // ******
  initial begin
    d_i = 16'sh0000;
    d_q = 16'sh0000;
    vld = 1'b0;
  end
  task automatic send(input logic signed [15:0] i, input logic signed [15:0] q);
    @(negedge clk);
    d_i = i;
    d_q = q;
    vld = 1'b1;
  endtask
  // Released lines flip, so stale data can never pass for fresh data
  task automatic stop();
    @(negedge clk);
    d_i = ~d_i;
    d_q = ~d_q;
    vld = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dv/dms_top_bench.sv
// Bench for the modulator, inverse sinc and clock path core.
// Assumes the design files and the source model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module dms_top_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic hb = 1'b0;
  logic so, soe, dv, dvin, cfm, fs;
  logic signed [15:0] di, dq, oi, oq;
  logic [6:0] vm;
  logic [3:0] sm, inf, lbw;
  logic [5:0] bs;
  logic [1:0] vd;
  logic [2:0] pb;
  logic [7:0] r1 = 8'h00;
  logic [7:0] r8 = 8'h00;
  logic [7:0] r9 = 8'h00;
  logic [7:0] ra = 8'h00;
  logic [7:0] rd;
  logic [15:0] rows[10] = '{16'h08ff, 16'h0923, 16'h09cb, 16'h0a0f, 16'h0a1f,
    16'h0a00, 16'h0900, 16'h01c4, 16'h0150, 16'h0800};
  logic [3:0] modes[7] = '{4'h8, 4'h4, 4'hc, 4'h2, 4'h6, 4'he, 4'h0};
  int h[9] = '{2, -4, 10, -35, 401, -35, 10, -4, 2};
  int n_fail = 0;
  int num_checks = 0;
  logic signed [15:0] qi[$];
  logic signed [15:0] qq[$];
  wire logic sdio = soe ? so : hb;
  wire logic [31:0] outs = {cfm, vm, sm, inf, fs, bs, vd, pb, lbw};
  dms_src_model u_src (.clk(clk), .d_i(di), .d_q(dq), .vld(dvin));
  dms_top #(.W(16)) u_dut (.CLK(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SDIO_IN(sdio),
    .SDIO_OUT(so), .SDIO_OE(soe), .DATA_I(di), .DATA_Q(dq), .DATA_VALID(dvin),
    .DAC_I(oi), .DAC_Q(oq), .DAC_VALID(dv), .CLK_FROM_MULT(cfm), .VCO_MULT(vm),
    .SAMPLE_MULT(sm), .INTERP_FACTOR(inf), .FILTER_SHIFTED(fs), .BAND_SEL(bs),
    .VCO_DRIVE(vd), .PLL_BIAS(pb), .LOOP_BW_MHZ(lbw));
  // **************
  // Shared helpers
  // **************
  initial forever #25 clk = ~clk;
  always @(negedge clk) begin
    if (dv === 1'b1) begin
      qi.push_back(oi);
      qq.push_back(oq);
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Odd 45 degree phases may differ by one count of rounding
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g, input int tol);
    num_checks++;
    if (g !== e && !(tol > 0 && (g - e == 1 || e - g == 1))) begin
      n_fail++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  // Slow serial edges: the core resynchronises the pins
  task automatic sbyte(input logic [7:0] b, output logic [7:0] r);
    for (int k = 7; k >= 0; k--) begin
      hb = b[k];
      repeat (5) @(negedge clk);
      r[k] = so;
      sclk = 1'b1;
      repeat (5) @(negedge clk);
      sclk = 1'b0;
    end
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
    logic [7:0] x;
    cs_n = 1'b0;
    sbyte(a, x);
    sbyte(d, r);
    repeat (5) @(negedge clk);
    cs_n = 1'b1;
    repeat (8) @(negedge clk);
  endtask
  function automatic logic [31:0] expv();
    logic [3:0] lb;
    lb = (ra[4:0] == 5'h1f) ? 4'ha : (ra[4:0] == 5'h0f) ? 4'h3 : 4'h1;
    return {r9[7], 7'(1 << ({1'b0, r9[6:5]} + r9[4:3])), 4'(1 << r9[4:3]),
      4'(1 << r1[7:6]), r1[2], r8, r9[2:0], lb};
  endfunction
  // ****
  // Main
  // ****
  initial begin
    logic [7:0] x;
    int p, ei, eq;
    real a;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    chk("outs", expv(), outs, 0);
    acc(8'h82, 8'h00, rd);
    chk("dp_opt", 0, rd, 0);
    foreach (rows[n]) begin
      acc(rows[n][15:8], rows[n][7:0], x);
      case (rows[n][15:8])
        8'h01: r1 = rows[n][7:0];
        8'h08: r8 = rows[n][7:0];
        8'h09: r9 = rows[n][7:0];
        default: ra = rows[n][7:0];
      endcase
      acc(8'h80 | rows[n][15:8], 8'h00, rd);
      chk("readback", rows[n][7:0], rd, 0);
      chk("outs", expv(), outs, 0);
    end
    foreach (modes[m]) begin
      acc(8'h01, {2'b11, modes[m], 2'b00}, x);
      qi.delete();
      qq.delete();
      for (int k = 0; k < 8; k++) u_src.send(16'(1000 + 100 * k), 16'(50 * k - 3000));
      u_src.stop();
      repeat (8) @(negedge clk);
      chk("count", 8, qi.size(), 0);
      for (int k = 0; k < 8; k++) begin
        p = (k * modes[m][3:1]) % 8;
        a = p * 3.14159265358979 / 4.0;
        ei = int'((1000 + 100 * k) * $cos(a) + (50 * k - 3000) * $sin(a));
        eq = int'((50 * k - 3000) * $cos(a) - (1000 + 100 * k) * $sin(a));
        chk("mix_i", ei, qi[k], p % 2);
        chk("mix_q", eq, qq[k], p % 2);
      end
    end
    acc(8'h01, 8'hc0, x);
    acc(8'h02, 8'h08, x);
    qi.delete();
    for (int k = 0; k < 18; k++) u_src.send((k == 9) ? 16'sh03e8 : 16'sh0000, 16'sh0000);
    u_src.stop();
    repeat (8) @(negedge clk);
    for (int k = 0; k < 9; k++) chk("isinc", (h[k] * 1000 + 256) >>> 9, qi[9 + k], 0);
    acc(8'h05, 8'hff, x);
    acc(8'h85, 8'h00, rd);
    chk("unmapped", 0, rd, 0);
    summarize();
  end
  initial begin
    #2000000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire

// File: verilog/dms_defines.svh
// Offsets, field positions, reset values and filter constants for the
// modulator, inverse sinc and clock path block. Definitions only.
`ifndef DMS_DEFINES_SVH
`define DMS_DEFINES_SVH
`define DMS_ADDR_FILT_MODE 5'h01
`define DMS_ADDR_DP_OPT 5'h02
`define DMS_ADDR_VCO_BAND 5'h08
`define DMS_ADDR_MULT_CFG 5'h09
`define DMS_ADDR_LOOP_BW 5'h0a
`define DMS_RST_FILT_MODE 8'h00
`define DMS_RST_DP_OPT 8'h00
`define DMS_RST_VCO_BAND 8'h00
`define DMS_RST_MULT_CFG 8'h00
`define DMS_RST_LOOP_BW 8'h00
`define DMS_INTERP_MSB 7
`define DMS_INTERP_LSB 6
`define DMS_MODE_MSB 5
`define DMS_MODE_LSB 2
`define DMS_BIT_REAL 5
`define DMS_BIT_ISINC 3
`define DMS_BIT_MULT_EN 7
`define DMS_VCO_RATIO_MSB 6
`define DMS_VCO_RATIO_LSB 5
`define DMS_SMP_RATIO_MSB 4
`define DMS_SMP_RATIO_LSB 3
`define DMS_BIAS_MSB 2
`define DMS_BAND_MSB 7
`define DMS_BAND_LSB 2
`define DMS_DRIVE_MSB 1
`define DMS_LBW_MSB 4
`define DMS_LBW_KNEE 5'h0f
`define DMS_ISINC_C0 12'sh002
`define DMS_ISINC_C1 (-12'sh004)
`define DMS_ISINC_C2 12'sh00a
`define DMS_ISINC_C3 (-12'sh023)
`define DMS_ISINC_C4 12'sh191
`define DMS_ISINC_SHIFT 9
`define DMS_ROOT_HALF 16'sh5a82
`define DMS_ROOT_SHIFT 15
`endif

// File: verilog/dms_isinc.sv
// Nine-tap symmetric inverse sinc stage with bypass, one per channel.
// Assumes one sample per valid cycle; latency is one valid either way.
`timescale 1ns/100ps
`default_nettype none
`include "dms_defines.svh"
module dms_isinc
  import dms_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  dms_smp_if.snk din,
  dms_smp_if.src dout
);
  localparam int AW = W + 12;
  localparam logic signed [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};
  logic vld_q;

  function automatic logic signed [W-1:0] sat(input logic signed [AW-1:0] v);
    if (v > AW'(~MINV)) sat = ~MINV;
    else if (v < AW'(MINV)) sat = MINV;
    else sat = W'(v);
  endfunction

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      logic signed [W-1:0] x;
      logic signed [W-1:0] tap_q [8];
      logic signed [W-1:0] y_q;
      logic signed [AW-1:0] acc;
      assign x = (c == 0) ? din.i : din.q;
      always_comb begin
        acc = `DMS_ISINC_C0 * (AW'(x) + AW'(tap_q[7]))
            + `DMS_ISINC_C1 * (AW'(tap_q[0]) + AW'(tap_q[6]))
            + `DMS_ISINC_C2 * (AW'(tap_q[1]) + AW'(tap_q[5]))
            + `DMS_ISINC_C3 * (AW'(tap_q[2]) + AW'(tap_q[4]))
            + `DMS_ISINC_C4 * AW'(tap_q[3]);
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          for (int k = 0; k < 8; k++) tap_q[k] <= '0;
          y_q <= '0;
        end else if (din.valid) begin
          tap_q[0] <= x;
          for (int k = 1; k < 8; k++) tap_q[k] <= tap_q[k-1];
          // Coefficients sum to 347 of 512: the built-in 3.4 dB loss
          if (en) y_q <= sat((acc + AW'(256)) >>> `DMS_ISINC_SHIFT);
          else y_q <= x;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) vld_q <= 1'b0;
    else vld_q <= din.valid;
  end

  assign dout.i = g_ch[0].y_q;
  assign dout.q = g_ch[1].y_q;
  assign dout.valid = vld_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_bypass;
    (!en && din.valid) |=> (dout.i == $past(din.i) && dout.q == $past(din.q));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not transparent");
  property p_lat;
    din.valid |=> dout.valid;
  endproperty
  a_lat: assert property (p_lat) else $error("filter latency wrong");
endmodule
`default_nettype wire

// File: verilog/dms_pkg.sv
// Types shared by the modulator, inverse sinc and clock path block.
// Assumes nothing beyond a SystemVerilog compiler.
package dms_pkg;
  typedef enum logic [3:0] {
    DMS_SP_IDLE = 4'b0001,
    DMS_SP_INSTR = 4'b0010,
    DMS_SP_WRITE = 4'b0100,
    DMS_SP_READ = 4'b1000
  } dms_sp_state_t;
  typedef logic [2:0] dms_eighth_t;
endpackage

// File: verilog/dms_qmod.sv
// Coarse quadrature mixer rotating I/Q by multiples of 45 degrees.
// Assumes the step input is steady between configuration writes.
`timescale 1ns/100ps
`default_nettype none
`include "dms_defines.svh"
module dms_qmod
  import dms_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire dms_eighth_t step,
  input wire logic real_only,
  dms_smp_if.snk din,
  dms_smp_if.src dout
);
  localparam logic signed [W-1:0] MINV = {1'b1, {(W-1){1'b0}}};
  dms_eighth_t step_q;
  dms_eighth_t phase_q;
  logic signed [W-1:0] i_q;
  logic signed [W-1:0] q_q;
  logic vld_q;
  logic [2:0] cc;
  logic [2:0] sc;
  logic signed [W+1:0] ni;
  logic signed [W+1:0] nq;
  logic signed [W+16:0] ni_w;
  logic signed [W+16:0] nq_w;

  // Weight codes: 1 plus one, 2 minus one, 3 plus r, 4 minus r, else zero.
  // Terms keep their fraction bits so each sum is rounded only once.
  function automatic logic signed [W+16:0] mulc(input logic signed [W-1:0] x,
                                                input logic [2:0] c);
    case (c)
      3'h1: mulc = (W+17)'(x) <<< `DMS_ROOT_SHIFT;
      3'h2: mulc = -((W+17)'(x) <<< `DMS_ROOT_SHIFT);
      3'h3: mulc = (W+17)'(x) * (W+17)'(`DMS_ROOT_HALF);
      3'h4: mulc = -((W+17)'(x) * (W+17)'(`DMS_ROOT_HALF));
      default: mulc = '0;
    endcase
  endfunction

  function automatic logic [2:0] cos_code(input dms_eighth_t a);
    case (a)
      3'h0: cos_code = 3'h1;
      3'h1: cos_code = 3'h3;
      3'h3: cos_code = 3'h4;
      3'h4: cos_code = 3'h2;
      3'h5: cos_code = 3'h4;
      3'h7: cos_code = 3'h3;
      default: cos_code = 3'h0;
    endcase
  endfunction

  // The 45 degree sums reach 1.41 of full scale, hence the clamp
  function automatic logic signed [W-1:0] sat(input logic signed [W+1:0] v);
    if (v > (W+2)'(~MINV)) sat = ~MINV;
    else if (v < (W+2)'(MINV)) sat = MINV;
    else sat = W'(v);
  endfunction

  always_comb begin
    cc = cos_code(phase_q);
    sc = cos_code(phase_q - 3'h2);
    ni_w = mulc(din.i, cc) + mulc(din.q, sc);
    nq_w = mulc(din.q, cc) - mulc(din.i, sc);
    ni = (W+2)'((ni_w + ((W+17)'(1) <<< (`DMS_ROOT_SHIFT - 1))) >>> `DMS_ROOT_SHIFT);
    nq = (W+2)'((nq_w + ((W+17)'(1) <<< (`DMS_ROOT_SHIFT - 1))) >>> `DMS_ROOT_SHIFT);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      step_q <= '0;
      phase_q <= '0;
    end else begin
      step_q <= step;
      if (step != step_q) phase_q <= '0;
      else if (din.valid) phase_q <= phase_q + step_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i_q <= '0;
      q_q <= '0;
      vld_q <= 1'b0;
    end else begin
      vld_q <= din.valid;
      if (din.valid) begin
        i_q <= sat(ni);
        q_q <= real_only ? '0 : sat(nq);
      end
    end
  end

  assign dout.i = i_q;
  assign dout.q = q_q;
  assign dout.valid = vld_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_restart;
    (step != step_q) |=> (phase_q == 3'h0);
  endproperty
  a_restart: assert property (p_restart) else $error("phase not restarted");
  property p_half;
    (step_q == 3'h4 && step == step_q && din.valid && phase_q == 3'h4 && din.i != MINV)
      |=> (dout.i == -$past(din.i));
  endproperty
  a_half: assert property (p_half) else $error("half rate sign wrong");
  property p_quarter;
    (step_q == 3'h2 && step == step_q && din.valid && phase_q == 3'h2)
      |=> (dout.i == $past(din.q));
  endproperty
  a_quarter: assert property (p_quarter) else $error("quarter rate wrong");
  property p_negq;
    (step_q == 3'h6 && step == step_q && din.valid && phase_q == 3'h6 && din.q != MINV)
      |=> (dout.i == -$past(din.q));
  endproperty
  a_negq: assert property (p_negq) else $error("neg quarter wrong");
  property p_eighth;
    (step_q == 3'h1 && step == step_q && din.valid && phase_q == 3'h4 && din.i != MINV)
      |=> (dout.i == -$past(din.i));
  endproperty
  a_eighth: assert property (p_eighth) else $error("eighth rate wrong");
endmodule
`default_nettype wire

// File: verilog/dms_smp_if.sv
// Sample carrier between datapath stages: one I/Q pair per valid cycle.
// Assumes producer and consumer share the sample clock.
`timescale 1ns/100ps
`default_nettype none
interface dms_smp_if #(
  parameter int W = 16
);
  logic signed [W-1:0] i;
  logic signed [W-1:0] q;
  logic valid;
  modport src(output i, output q, output valid);
  modport snk(input i, input q, input valid);
endinterface
`default_nettype wire

// File: verilog/dms_top.sv
// Transmit datapath core: coarse modulator, inverse sinc, clock path
// controls and the 3-wire serial register port.
// Assumes sample data arrive on CLK-aligned pins, resynchronised here.
//
// How it works
// - Modulator shifts spectrum by data-rate multiples
// - Half rate flips sign of I, Q
// - Positive quarter rate rotates I/Q forward
// - Negative quarter rate rotates I/Q backward
// - Eighth rate uses eight-step 45 degree rotation
// - Only half rate keeps channels independent
// - Three-eighths shift available only at 8x
// - Shifted and nonshifted filter selectable by mode
// - Pass band 0.8 of data rate centred
// - Edges 0.4 nonshifted, 0.1 shifted
// - Inverse sinc is nine-tap symmetric FIR
// - Taps 2, -4, 10, -35, 401 mirrored
// - Ripple within 0.05 dB to 0.4
// - Inverse sinc has 3.4 dB built-in loss
// - Inverse sinc off at reset, bit enables
// - Multiplier off: reference drives sample clock
// - Multiplier on: ratios set VCO, sample clock
// - Loop bandwidth code maps 1, 3, 10 MHz
// - Mode field bits 5:2, interpolation bits 7:6
`timescale 1ns/100ps
`default_nettype none
`include "dms_defines.svh"
module dms_top
  import dms_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDIO_IN,
  output logic SDIO_OUT,
  output logic SDIO_OE,
  input wire logic signed [W-1:0] DATA_I,
  input wire logic signed [W-1:0] DATA_Q,
  input wire logic DATA_VALID,
  output logic signed [W-1:0] DAC_I,
  output logic signed [W-1:0] DAC_Q,
  output logic DAC_VALID,
  output logic CLK_FROM_MULT,
  output logic [6:0] VCO_MULT,
  output logic [3:0] SAMPLE_MULT,
  output logic [3:0] INTERP_FACTOR,
  output logic FILTER_SHIFTED,
  output logic [5:0] BAND_SEL,
  output logic [1:0] VCO_DRIVE,
  output logic [2:0] PLL_BIAS,
  output logic [3:0] LOOP_BW_MHZ
);
  // ****************************************
  // Declarations
  // ****************************************
  dms_sp_state_t st_q;
  logic [2:0] sclk_s_q;
  logic [1:0] csn_s_q;
  logic [1:0] sdi_s_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [4:0] addr_q;
  logic sdo_q;
  logic oe_q;
  logic wr_q;
  logic [4:0] wr_addr_q;
  logic [7:0] wr_data_q;
  logic sclk_rise;
  logic cs_act;
  logic [7:0] byte_in;
  logic [7:0] mode_q;
  logic [7:0] opt_q;
  logic [7:0] band_q;
  logic [7:0] mult_q;
  logic [7:0] lbw_q;
  logic signed [W-1:0] di_s_q [2];
  logic signed [W-1:0] dq_s_q [2];
  logic [1:0] dv_s_q;
  dms_eighth_t step;
  dms_smp_if #(.W(W)) raw_if ();
  dms_smp_if #(.W(W)) mod_if ();
  dms_smp_if #(.W(W)) fir_if ();

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [7:0] rd_mux(input logic [4:0] a);
    case (a)
      `DMS_ADDR_FILT_MODE: rd_mux = mode_q;
      `DMS_ADDR_DP_OPT: rd_mux = opt_q;
      `DMS_ADDR_VCO_BAND: rd_mux = band_q;
      `DMS_ADDR_MULT_CFG: rd_mux = mult_q;
      `DMS_ADDR_LOOP_BW: rd_mux = lbw_q;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Eighths of the sample rate advanced per output sample; 3/8 only
  // exists when the interpolation code selects 8x
  function automatic dms_eighth_t step_of(input logic [7:0] m, input logic real_md);
    logic [3:0] md;
    md = m[`DMS_MODE_MSB:`DMS_MODE_LSB];
    if (real_md) step_of = 3'h0;
    else begin
      case (m[`DMS_INTERP_MSB:`DMS_INTERP_LSB])
        2'h3: step_of = md[3:1];
        2'h2: step_of = {md[2:1], 1'b0};
        2'h1: step_of = {md[1], 2'b00};
        default: step_of = 3'h0;
      endcase
    end
  endfunction

  // Coarse loop filter bandwidth in MHz: 0 -> 1, 15 -> 3, 31 -> 10
  function automatic logic [3:0] lbw_mhz(input logic [4:0] c);
    logic [7:0] t;
    t = 8'h00;
    if (c <= `DMS_LBW_KNEE) begin
      t = 8'h01 + (8'(c) * 8'h02) / 8'h0f;
    end else begin
      t = 8'h03 + (8'(c - `DMS_LBW_KNEE) * 8'h07) / 8'h10;
    end
    lbw_mhz = t[3:0];
  endfunction

  // ****************************************
  // Serial port synchronisers
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sclk_s_q <= 3'h0;
      csn_s_q <= 2'h3;
      sdi_s_q <= 2'h0;
    end else begin
      sclk_s_q <= {sclk_s_q[1:0], SCLK};
      csn_s_q <= {csn_s_q[0], CS_N};
      sdi_s_q <= {sdi_s_q[0], SDIO_IN};
    end
  end

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign cs_act = ~csn_s_q[1];
  assign byte_in = {sh_q[6:0], sdi_s_q[1]};

  // ****************************************
  // Serial port sequencer
  // ****************************************
  // One instruction byte (bit 7 read, bits 4:0 address), one data byte;
  // after each data byte a new instruction follows while select is low.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= DMS_SP_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      addr_q <= 5'h00;
      sdo_q <= 1'b0;
    end else if (!cs_act) begin
      st_q <= DMS_SP_IDLE;
      bit_q <= 3'h0;
    end else begin
      case (st_q)
        DMS_SP_IDLE: begin
          st_q <= DMS_SP_INSTR;
          bit_q <= 3'h0;
        end
        DMS_SP_INSTR: begin
          if (sclk_rise) begin
            bit_q <= bit_q + 3'h1;
            sh_q <= byte_in;
            if (bit_q == 3'h7) begin
              addr_q <= byte_in[4:0];
              if (byte_in[7]) begin
                st_q <= DMS_SP_READ;
                sdo_q <= 1'(rd_mux(byte_in[4:0]) >> 7);
                sh_q <= rd_mux(byte_in[4:0]) << 1;
              end else begin
                st_q <= DMS_SP_WRITE;
              end
            end
          end
        end
        DMS_SP_WRITE: begin
          if (sclk_rise) begin
            bit_q <= bit_q + 3'h1;
            sh_q <= byte_in;
            if (bit_q == 3'h7) st_q <= DMS_SP_INSTR;
          end
        end
        DMS_SP_READ: begin
          // Next bit is put out just after the edge the host samples on
          if (sclk_rise) begin
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) st_q <= DMS_SP_INSTR;
            else begin
              sdo_q <= sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
        end
        default: begin
          st_q <= DMS_SP_IDLE;
          bit_q <= 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) oe_q <= 1'b0;
    else oe_q <= cs_act && (st_q == DMS_SP_READ);
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      wr_q <= 1'b0;
      wr_addr_q <= 5'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_q <= cs_act && (st_q == DMS_SP_WRITE) && sclk_rise && (bit_q == 3'h7);
      wr_addr_q <= addr_q;
      wr_data_q <= byte_in;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_q <= `DMS_RST_FILT_MODE;
      opt_q <= `DMS_RST_DP_OPT;
      band_q <= `DMS_RST_VCO_BAND;
      mult_q <= `DMS_RST_MULT_CFG;
      lbw_q <= `DMS_RST_LOOP_BW;
    end else if (wr_q) begin
      case (wr_addr_q)
        `DMS_ADDR_FILT_MODE: mode_q <= wr_data_q;
        `DMS_ADDR_DP_OPT: opt_q <= wr_data_q;
        `DMS_ADDR_VCO_BAND: band_q <= wr_data_q;
        `DMS_ADDR_MULT_CFG: mult_q <= wr_data_q;
        `DMS_ADDR_LOOP_BW: lbw_q <= wr_data_q;
        default: ;
      endcase
    end
  end

  // ****************************************
  // Clock path controls
  // ****************************************
  // The clock mux and PLL are analog; these flops steer them.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CLK_FROM_MULT <= 1'b0;
      VCO_MULT <= 7'h01;
      SAMPLE_MULT <= 4'h1;
      BAND_SEL <= 6'h00;
      VCO_DRIVE <= 2'h0;
      PLL_BIAS <= 3'h0;
      LOOP_BW_MHZ <= 4'h1;
    end else begin
      CLK_FROM_MULT <= mult_q[`DMS_BIT_MULT_EN];
      VCO_MULT <= 7'h01 << ({1'b0, mult_q[`DMS_VCO_RATIO_MSB:`DMS_VCO_RATIO_LSB]}
                           + {1'b0, mult_q[`DMS_SMP_RATIO_MSB:`DMS_SMP_RATIO_LSB]});
      SAMPLE_MULT <= 4'h1 << mult_q[`DMS_SMP_RATIO_MSB:`DMS_SMP_RATIO_LSB];
      BAND_SEL <= band_q[`DMS_BAND_MSB:`DMS_BAND_LSB];
      VCO_DRIVE <= band_q[`DMS_DRIVE_MSB:0];
      PLL_BIAS <= mult_q[`DMS_BIAS_MSB:0];
      LOOP_BW_MHZ <= lbw_mhz(lbw_q[`DMS_LBW_MSB:0]);
    end
  end

  // ****************************************
  // Sample input and mode decode
  // ****************************************
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      di_s_q[0] <= '0;
      di_s_q[1] <= '0;
      dq_s_q[0] <= '0;
      dq_s_q[1] <= '0;
      dv_s_q <= 2'h0;
    end else begin
      di_s_q[0] <= DATA_I;
      di_s_q[1] <= di_s_q[0];
      dq_s_q[0] <= DATA_Q;
      dq_s_q[1] <= dq_s_q[0];
      dv_s_q <= {dv_s_q[0], DATA_VALID};
    end
  end

  assign raw_if.i = di_s_q[1];
  assign raw_if.q = dq_s_q[1];
  assign raw_if.valid = dv_s_q[1];
  assign step = step_of(mode_q, opt_q[`DMS_BIT_REAL]);

  // Band edges (0.8 centred, 0.4 / 0.1 at the edges) belong to the
  // interpolation stages; this block exports which variant is chosen.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      FILTER_SHIFTED <= 1'b0;
      INTERP_FACTOR <= 4'h1;
    end else begin
      FILTER_SHIFTED <= mode_q[`DMS_MODE_LSB];
      INTERP_FACTOR <= 4'h1 << mode_q[`DMS_INTERP_MSB:`DMS_INTERP_LSB];
    end
  end

  // ****************************************
  // Datapath
  // ****************************************
  dms_qmod #(.W(W)) u_qmod (
    .clk(CLK),
    .rst(RST),
    .step(step),
    .real_only(opt_q[`DMS_BIT_REAL]),
    .din(raw_if.snk),
    .dout(mod_if.src)
  );

  dms_isinc #(.W(W)) u_isinc (
    .clk(CLK),
    .rst(RST),
    .en(opt_q[`DMS_BIT_ISINC]),
    .din(mod_if.snk),
    .dout(fir_if.src)
  );

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      DAC_I <= '0;
      DAC_Q <= '0;
      DAC_VALID <= 1'b0;
    end else begin
      DAC_I <= fir_if.i;
      DAC_Q <= fir_if.q;
      DAC_VALID <= fir_if.valid;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      SDIO_OUT <= 1'b0;
      SDIO_OE <= 1'b0;
    end else begin
      SDIO_OUT <= sdo_q;
      SDIO_OE <= oe_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  sequence s_wr_mult;
    wr_q && (wr_addr_q == `DMS_ADDR_MULT_CFG);
  endsequence
  property p_clk_sel;
    s_wr_mult |-> ##2 (CLK_FROM_MULT == $past(wr_data_q[`DMS_BIT_MULT_EN], 2));
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock source wrong");
  property p_ratio;
    VCO_MULT == (7'(SAMPLE_MULT) << $past(mult_q[`DMS_VCO_RATIO_MSB:`DMS_VCO_RATIO_LSB]));
  endproperty
  a_ratio: assert property (p_ratio) else $error("vco ratio wrong");
  property p_lbw;
    (lbw_q[`DMS_LBW_MSB:0] == `DMS_LBW_KNEE) |=> (LOOP_BW_MHZ == 4'h3);
  endproperty
  a_lbw: assert property (p_lbw) else $error("loop bw map wrong");
  property p_real;
    opt_q[`DMS_BIT_REAL] |-> (step == 3'h0);
  endproperty
  a_real: assert property (p_real) else $error("real mode mixes");
endmodule
`default_nettype wire
